// ===== ttk_time_keeper.sv
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Purpose: Seconds and eighth-second tick keeper with follower sync
// Assumes: Tick and delivery strobes synchronous to clk_sys
// Notes: Delivered seconds are taken as-is, no plausibility test
module ttk_time_keeper
  import ttk_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Spacecraft bus interface
  input wire logic eighth_second_tick,
  input wire logic sc_time_stb,
  input wire logic [31:0] sc_time_val,
  // Follower processors
  output logic fine_sync_r,
  output logic poke_valid_r,
  output logic poke_dest_r,
  output logic [23:0] poke_data_r,
  input wire logic poke_ready,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_r,
  // Interrupt
  output logic irq_r
);

  // ----------------------------------------
  // Time state
  // ----------------------------------------
  logic [TTK_SEC_W-1:0] seconds_r;
  logic [TTK_SEC_W-1:0] pending_r;
  logic [TTK_TICK_W-1:0] tick_r;
  logic delivered_r;
  logic arrived_r;
  logic [TTK_ST_W-1:0] status_r;
  logic [TTK_ST_W-1:0] irq_en_r;
  logic [31:0] ctrl_r;
  logic [TTK_SEC_W-1:0] seconds_nxt;
  logic [TTK_TICK_W-1:0] tick_nxt;

  wire enabled = ctrl_r[TTK_CTRL_EN];
  wire tick_p = eighth_second_tick && enabled;
  wire detect = tick_p && (tick_r == TTK_DETECT_TICK - 3'h1) && delivered_r;
  wire load = tick_p && arrived_r;
  wire overflow = tick_p && !arrived_r && (tick_r == TTK_DETECT_TICK);

  // Seconds and tick next-state; the tick pulse itself is trusted
  // to be an exact eighth second, so no drift correction is tried
  always_comb begin
    seconds_nxt = seconds_r;
    tick_nxt = tick_r;
    if (load) begin
      seconds_nxt = pending_r;
      tick_nxt = 3'h0;
    end else if (tick_p) begin
      tick_nxt = tick_r + 3'h1;
      if (overflow) begin
        seconds_nxt = seconds_r + 32'h0000_0001;
      end
    end
  end

  // Period zero begins on load or on overflow, same as follower view
  wire period0_start = load || overflow;
  wire [7:0] sec_low_nxt = seconds_nxt[TTK_FINE_W-1:0];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      seconds_r <= 32'h0000_0000;
      tick_r <= 3'h0;
      pending_r <= 32'h0000_0000;
      delivered_r <= 1'b0;
      arrived_r <= 1'b0;
    end else begin
      seconds_r <= seconds_nxt;
      tick_r <= tick_nxt;
      // Delivery expected in tick six; latch any value
      if (sc_time_stb) begin
        pending_r <= sc_time_val;
        delivered_r <= 1'b1;
      end else if (detect) begin
        delivered_r <= 1'b0;
      end
      if (detect) begin
        arrived_r <= 1'b1;
      end else if (load) begin
        arrived_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Follower synchronisation
  // ----------------------------------------
  logic sync_evt;
  logic poke_done;
  logic poke_late;

  ttk_sync_pulse u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .tick_p(tick_p),
    .period0_start(period0_start),
    .sec_low(sec_low_nxt),
    .fine_sync_r(fine_sync_r),
    .sync_evt_r(sync_evt)
  );

  ttk_poke_seq u_poke (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(sync_evt),
    .tick_p(tick_p),
    .coarse(seconds_r[TTK_SEC_W-1:TTK_FINE_W]),
    .poke_valid_r(poke_valid_r),
    .poke_dest_r(poke_dest_r),
    .poke_data_r(poke_data_r),
    .poke_ready(poke_ready),
    .done_r(poke_done),
    .late_r(poke_late)
  );

  // ----------------------------------------
  // Registers and interrupt
  // ----------------------------------------
  wire wr_en = reg_wr && (reg_addr == TTK_REG_IRQ_EN);
  wire wr_clr = reg_wr && (reg_addr == TTK_REG_IRQ_CLR);
  wire wr_ctrl = reg_wr && (reg_addr == TTK_REG_CTRL);

  logic [TTK_ST_W-1:0] events;
  assign events[TTK_ST_ARRIVED] = detect;
  assign events[TTK_ST_LOADED] = load;
  assign events[TTK_ST_FREERUN] = overflow;
  assign events[TTK_ST_SYNC] = sync_evt;
  assign events[TTK_ST_POKED] = poke_done || poke_late;

  logic [TTK_ST_W-1:0] clr_bits;
  assign clr_bits = wr_clr ? reg_wdata[TTK_ST_W-1:0] : '0;

  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      TTK_REG_SECONDS: rd_mux = seconds_r;
      TTK_REG_TICK: rd_mux = {29'h0, tick_r};
      TTK_REG_PENDING: rd_mux = pending_r;
      TTK_REG_STATUS: rd_mux = {27'h0, status_r};
      TTK_REG_IRQ_EN: rd_mux = {27'h0, irq_en_r};
      TTK_REG_CTRL: rd_mux = ctrl_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_r <= '0;
      irq_en_r <= '0;
      ctrl_r <= TTK_CTRL_RST;
      reg_rdata_r <= 32'h0000_0000;
      irq_r <= 1'b0;
    end else begin
      // Set beats clear so an event in the clear cycle survives
      status_r <= (status_r & ~clr_bits) | events;
      if (wr_en) begin
        irq_en_r <= reg_wdata[TTK_ST_W-1:0];
      end
      if (wr_ctrl) begin
        ctrl_r <= {31'h0, reg_wdata[TTK_CTRL_EN]};
      end
      reg_rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
      irq_r <= |(status_r & irq_en_r);
    end
  end

endmodule

// ===== ttk_pkg.sv
// Purpose: Constants and types shared by the tick time keeper
// Assumes: One 125 MHz clock, tick pulse already synchronous
// Notes: Register map is reached over a plain strobe port
//
// Functional notes
// - Tick seven: capture pending time, raise arrival flag
// - Next tick: load pending seconds, zero tick field
// - Each tick pulse without a load increments the tick field
// - Tick overflow increments seconds without delivery
// - Tick zero, low seconds byte zero: fine sync
// - Within two ticks send coarse poke commands
// - Fine sync aligned to tick, shared tick
// - Follower sync repeats every 256 seconds
// - Free-running master still issues sync and coarse
// - Delivered time accepted without any validity check
package ttk_pkg;

  localparam int TTK_TICK_W = 3;
  localparam int TTK_SEC_W = 32;
  localparam int TTK_FINE_W = 8;
  localparam int TTK_COARSE_W = 24;
  localparam logic [2:0] TTK_DELIVER_TICK = 3'h6;
  localparam logic [2:0] TTK_DETECT_TICK = 3'h7;
  localparam logic [2:0] TTK_POKE_DEADLINE = 3'h2;

  // Register offsets (byte addresses)
  localparam logic [7:0] TTK_REG_SECONDS = 8'h00;
  localparam logic [7:0] TTK_REG_TICK = 8'h04;
  localparam logic [7:0] TTK_REG_PENDING = 8'h08;
  localparam logic [7:0] TTK_REG_STATUS = 8'h0c;
  localparam logic [7:0] TTK_REG_IRQ_EN = 8'h10;
  localparam logic [7:0] TTK_REG_IRQ_CLR = 8'h14;
  localparam logic [7:0] TTK_REG_CTRL = 8'h18;

  // Status bits
  localparam int TTK_ST_ARRIVED = 0;
  localparam int TTK_ST_LOADED = 1;
  localparam int TTK_ST_FREERUN = 2;
  localparam int TTK_ST_SYNC = 3;
  localparam int TTK_ST_POKED = 4;
  localparam int TTK_ST_W = 5;

  localparam int TTK_CTRL_EN = 0;
  localparam logic [31:0] TTK_CTRL_RST = 32'h0000_0001;

  typedef enum logic [1:0] {
    TTK_PK_IDLE,
    TTK_PK_SEND_A,
    TTK_PK_SEND_B
  } ttk_poke_type;

endpackage

// ===== ttk_sync_pulse.sv
`timescale 1ns/1ps
// Purpose: Fine-sync level for followers, aligned to tick periods
// Assumes: Tick pulse is one cycle wide
// Notes: Level holds for the whole of tick period zero
module ttk_sync_pulse
  import ttk_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Timing inputs
  input wire logic tick_p,
  input wire logic period0_start,
  input wire logic [7:0] sec_low,
  // Output
  output logic fine_sync_r,
  output logic sync_evt_r
);

  wire fire = tick_p && period0_start && (sec_low == 8'h00);

  // Changes only on tick edges, so every follower sees it for a full period
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fine_sync_r <= 1'b0;
      sync_evt_r <= 1'b0;
    end else begin
      sync_evt_r <= fire;
      if (tick_p) begin
        fine_sync_r <= fire;
      end
    end
  end

endmodule

// ===== ttk_poke_seq.sv
`timescale 1ns/1ps
// Purpose: Sends coarse time to both followers after a fine sync
// Assumes: Channel accepts a command with valid and ready
// Notes: Gives up at the deadline rather than stall timekeeping
module ttk_poke_seq
  import ttk_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Triggers
  input wire logic start,
  input wire logic tick_p,
  input wire logic [23:0] coarse,
  // Channel
  output logic poke_valid_r,
  output logic poke_dest_r,
  output logic [23:0] poke_data_r,
  input wire logic poke_ready,
  // Result
  output logic done_r,
  output logic late_r
);

  ttk_poke_type st_r;
  logic [2:0] ticks_r;
  wire accept = poke_valid_r && poke_ready;
  wire expired = tick_p && (ticks_r == TTK_POKE_DEADLINE - 3'h1);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= TTK_PK_IDLE;
      ticks_r <= 3'h0;
      poke_valid_r <= 1'b0;
      poke_dest_r <= 1'b0;
      poke_data_r <= 24'h00_0000;
      done_r <= 1'b0;
      late_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      late_r <= 1'b0;
      case (st_r)
        TTK_PK_IDLE: begin
          if (start) begin
            st_r <= TTK_PK_SEND_A;
            ticks_r <= 3'h0;
            poke_valid_r <= 1'b1;
            poke_dest_r <= 1'b0;
            poke_data_r <= coarse;
          end
        end
        TTK_PK_SEND_A: begin
          if (tick_p) begin
            ticks_r <= ticks_r + 3'h1;
          end
          if (accept) begin
            st_r <= TTK_PK_SEND_B;
            poke_dest_r <= 1'b1;
          end else if (expired) begin
            st_r <= TTK_PK_IDLE;
            poke_valid_r <= 1'b0;
            late_r <= 1'b1;
          end
        end
        TTK_PK_SEND_B: begin
          if (tick_p) begin
            ticks_r <= ticks_r + 3'h1;
          end
          if (accept) begin
            st_r <= TTK_PK_IDLE;
            poke_valid_r <= 1'b0;
            done_r <= 1'b1;
          end else if (expired) begin
            st_r <= TTK_PK_IDLE;
            poke_valid_r <= 1'b0;
            late_r <= 1'b1;
          end
        end
        default: begin
          st_r <= TTK_PK_IDLE;
          poke_valid_r <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ===== ttk_checker.sv
// Purpose: Port checks of the time keeper
// Assumes: One clock domain, synchronous reset
// Notes: Bound to the design top
`timescale 1ns/1ps
module ttk_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Watched ports
  input wire logic eighth_second_tick,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata_r,
  input wire logic fine_sync_r,
  input wire logic poke_valid_r,
  input wire logic poke_dest_r,
  input wire logic [23:0] poke_data_r,
  input wire logic poke_ready
);
  // ------------------------------
  // Checks
  // ------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence take_a_s;
    poke_valid_r && poke_ready && !poke_dest_r;
  endsequence
  sequence take_b_s;
    poke_valid_r && poke_ready && poke_dest_r;
  endsequence
  rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata_r == 32'h0000_0000)
    else $error("read data not zero outside answer cycle");
  sync_rise_a: assert property ($rose(fine_sync_r) |-> $past(eighth_second_tick))
    else $error("fine sync rose away from a tick");
  sync_hold_a: assert property (fine_sync_r && !eighth_second_tick |=> fine_sync_r)
    else $error("fine sync dropped inside period");
  sync_drop_a: assert property (fine_sync_r && eighth_second_tick |=> !fine_sync_r)
    else $error("fine sync outlived its period");
  poke_start_a: assert property ($rose(fine_sync_r) |=> $rose(poke_valid_r) && !poke_dest_r)
    else $error("first poke not started after sync");
  poke_wait_a: assert property (poke_valid_r && !poke_ready && !eighth_second_tick
    |=> poke_valid_r && $stable(poke_dest_r) && $stable(poke_data_r))
    else $error("poke changed before acceptance");
  poke_next_a: assert property (take_a_s |=> poke_valid_r && poke_dest_r && $stable(poke_data_r))
    else $error("second poke did not follow the first");
  poke_end_a: assert property (take_b_s |=> !poke_valid_r)
    else $error("poke valid held after second acceptance");
endmodule

bind ttk_time_keeper ttk_checker chk (.clk_sys, .srst, .eighth_second_tick, .reg_rd,
  .reg_rdata_r, .fine_sync_r, .poke_valid_r, .poke_dest_r, .poke_data_r, .poke_ready);

// ===== ttk_follower_model.sv
// Purpose: Two follower processors on the poke channel
// Assumes: Ready follows valid after a set wait
// Notes: Keeps each follower's seconds count
`timescale 1ns/1ps
module ttk_follower_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // From the time master
  input wire logic eighth_second_tick,
  input wire logic fine_sync_r,
  input wire logic poke_valid_r,
  input wire logic poke_dest_r,
  input wire logic [23:0] poke_data_r,
  input wire logic [3:0] wait_cycles,
  // Answer and follower time
  output logic poke_ready,
  output logic [31:0] time_a_r,
  output logic [31:0] time_b_r
);
  logic [3:0] wait_r;
  assign poke_ready = poke_valid_r && (wait_r == wait_cycles);
  always_ff @(posedge clk_sys) begin
    if (srst || !poke_valid_r || poke_ready) wait_r <= 4'h0;
    else wait_r <= wait_r + 4'h1;
  end
  // Both followers see the same tick as the master
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      time_a_r <= 32'h0000_0000;
      time_b_r <= 32'h0000_0000;
    end else begin
      if (eighth_second_tick && fine_sync_r) begin
        time_a_r[7:0] <= 8'h00;
        time_b_r[7:0] <= 8'h00;
      end
      if (poke_ready && !poke_dest_r) time_a_r[31:8] <= poke_data_r;
      if (poke_ready && poke_dest_r) time_b_r[31:8] <= poke_data_r;
    end
  end
endmodule

// ===== tick_time_keeper_sync_bench.sv
// Purpose: Self-checking bench of the time keeper
// Assumes: Tick every 8 cycles stands for one eighth second
// Notes: Follower model answers the poke channel
`timescale 1ns/1ps
module tick_time_keeper_sync_bench;
  import ttk_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic tick = 1'b0;
  logic stb = 1'b0;
  logic [31:0] val = 32'h0000_0000;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] wait_cycles = 4'h0;
  logic fine_sync_r, poke_valid_r, poke_dest_r, poke_ready, irq_r;
  logic [23:0] poke_data_r;
  logic [31:0] rdata, time_a, time_b, d;
  int errors = 0;
  int comparisons = 0;
  always #4 clk_sys = ~clk_sys;
  ttk_time_keeper dut (.clk_sys, .srst, .eighth_second_tick(tick), .sc_time_stb(stb),
    .sc_time_val(val), .fine_sync_r, .poke_valid_r, .poke_dest_r, .poke_data_r,
    .poke_ready, .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata_r(rdata), .irq_r);
  ttk_follower_model fol (.clk_sys, .srst, .eighth_second_tick(tick), .fine_sync_r,
    .poke_valid_r, .poke_dest_r, .poke_data_r, .wait_cycles, .poke_ready,
    .time_a_r(time_a), .time_b_r(time_b));
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    // Sample mid-cycle, away from the edge that clears the answer
    @(negedge clk_sys);
    v = rdata;
    @(posedge clk_sys);
  endtask
  // Exactly eight cycles per tick keeps the period constant
  task automatic ticks(input int n);
    repeat (n) begin
      tick <= 1'b1;
      @(posedge clk_sys);
      tick <= 1'b0;
      repeat (7) @(posedge clk_sys);
    end
  endtask
  task automatic wait_idle();
    int n = 0;
    while (poke_valid_r !== 1'b0 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 40) begin
      errors++;
      stop_test();
    end
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic s_reset();
    rd_reg(TTK_REG_CTRL, d);
    chk("ctrl", TTK_CTRL_RST, d);
    wr_reg(TTK_REG_SECONDS, 32'h5555_5555);
    rd_reg(TTK_REG_SECONDS, d);
    chk("seconds", 32'h0000_0000, d);
    rd_reg(8'h40, d);
    chk("unmapped", 32'h0000_0000, d);
  endtask
  task automatic s_freerun();
    wr_reg(TTK_REG_CTRL, 32'h0000_0000);
    ticks(1);
    rd_reg(TTK_REG_TICK, d);
    chk("tick off", 32'h0000_0000, d);
    wr_reg(TTK_REG_CTRL, TTK_CTRL_RST);
    ticks(7);
    rd_reg(TTK_REG_TICK, d);
    chk("tick", 32'h0000_0007, d);
    ticks(1);
    rd_reg(TTK_REG_SECONDS, d);
    chk("seconds", 32'h0000_0001, d);
    rd_reg(TTK_REG_TICK, d);
    chk("tick wrap", 32'h0000_0000, d);
  endtask
  task automatic s_deliver();
    wr_reg(TTK_REG_IRQ_EN, 32'h0000_0008);
    ticks(6);
    val <= 32'hABCD_EF00;
    stb <= 1'b1;
    @(posedge clk_sys);
    stb <= 1'b0;
    ticks(1);
    rd_reg(TTK_REG_STATUS, d);
    chk("arrived", 32'(1'b1), 32'(d[TTK_ST_ARRIVED]));
    rd_reg(TTK_REG_PENDING, d);
    chk("pending", 32'hABCD_EF00, d);
    chk("irq masked", 32'h0000_0000, 32'(irq_r));
    ticks(1);
    chk("fine sync", 32'h0000_0001, 32'(fine_sync_r));
    chk("irq", 32'h0000_0001, 32'(irq_r));
    rd_reg(TTK_REG_SECONDS, d);
    chk("loaded", 32'hABCD_EF00, d);
    rd_reg(TTK_REG_TICK, d);
    chk("tick zero", 32'h0000_0000, d);
    wait_idle();
    wr_reg(TTK_REG_IRQ_CLR, 32'h0000_0008);
    repeat (2) @(posedge clk_sys);
    chk("irq clear", 32'h0000_0000, 32'(irq_r));
    ticks(1);
    chk("follower a", 32'hABCD_EF00, time_a);
    chk("follower b", 32'hABCD_EF00, time_b);
  endtask
  task automatic s_wrap();
    wait_cycles <= 4'h3;
    ticks(2047);
    chk("resync", 32'h0000_0001, 32'(fine_sync_r));
    wait_idle();
    rd_reg(TTK_REG_STATUS, d);
    chk("poke done", 32'(1'b1), 32'(d[TTK_ST_POKED]));
    chk("freerun", 32'(1'b1), 32'(d[TTK_ST_FREERUN]));
    chk("loaded", 32'(1'b1), 32'(d[TTK_ST_LOADED]));
    ticks(1);
    chk("free a", 32'hABCD_F000, time_a);
    chk("free b", 32'hABCD_F000, time_b);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    s_reset();
    s_freerun();
    s_deliver();
    s_wrap();
    stop_test();
  end
endmodule
